//--- dss_pkg.sv
// package for the drive stop sequencer: settings codes, defaults, timing
// assumes a 100 MHz clock; times are held in 10 ms ticks
//
// Overview of operation
// R1: a selector at value 0 makes its input the direction; run/stop become three-wire
// R2: three-wire init code assigns the fifth terminal to the direction role
// R3: run held 50 ms or longer is latched and persists after release
// R4: stop method 0..3: decel, coast, dc brake, timed coast; fixed while running
// R5: method 0 ramps frequency down at the chosen deceleration time
// R6: below zero-speed level during decel, inject dc for the stop brake time
// R7: zero-speed level 0.0..10.0 Hz, default 0.5; never below minimum frequency
// R8: brake current is 0..100 percent of rating, default 50
// R9: stop brake time 0.00..10.00 s, default 0.50; zero skips stop injection
// R10: method 1 cuts output at once and the motor freewheels
// R11: after a coast stop, run is ignored until the minimum off time passes
// R12: method 2 waits the minimum off time, then injects dc current
// R13: method 2 brake length scales with stop time and frequency at stop
// R14: method 3 cuts output and ignores run for a time from frequency and decel
// R15: at start inject dc for the start brake time; zero skips it
// R16: operator lengthens the minimum off time if overcurrent occurs when stopping
// R17: two-wire mode runs forward on first input, reverse on second, stops on release
// R18: three-wire clears the latched run on stop inactive; direction from its input
`default_nettype none
package dss_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_MS = 10;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned RUN_HOLD_MS = 50;
    localparam int unsigned RUN_HOLD_CYC = CLK_HZ / 1000 * RUN_HOLD_MS;
    localparam logic [2:0] SEL_DIRECTION = 3'h0;
    localparam logic [15:0] INIT_THREE_WIRE = 16'h0d02; // 3330 decimal
    localparam logic [1:0] STOP_DECEL = 2'h0;
    localparam logic [1:0] STOP_COAST = 2'h1;
    localparam logic [1:0] STOP_DCBRAKE = 2'h2;
    localparam logic [1:0] STOP_TIMED = 2'h3;
    // frequencies in 0.1 Hz, times in 10 ms ticks
    localparam logic [15:0] ZERO_SPEED_DEF = 16'h0005;
    localparam logic [15:0] ZERO_SPEED_MAX = 16'h0064;
    localparam logic [6:0] BRAKE_PCT_DEF = 7'h32;
    localparam logic [6:0] BRAKE_PCT_MAX = 7'h64;
    localparam logic [15:0] STOP_BRAKE_DEF = 16'h0032;
    localparam logic [15:0] BRAKE_TIME_MAX = 16'h03e8;
    localparam logic [15:0] START_BRAKE_DEF = 16'h0000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_START_BRAKE = 3'h1, ST_RUN = 3'h3,
        ST_DECEL = 3'h2, ST_STOP_BRAKE = 3'h6, ST_OFF_WAIT = 3'h7,
        ST_INHIBIT = 3'h5
    } dss_state_type;
    typedef struct packed {
        logic [1:0] stop_method_select;
        logic [15:0] brake_start_frequency;
        logic [6:0] brake_current_percent;
        logic [15:0] start_brake_time;
        logic [15:0] stop_brake_time;
        logic [15:0] min_output_off_time;
        logic [15:0] min_output_frequency;
        logic [15:0] first_decel_time;
        logic [15:0] max_output_frequency;
    } dss_cfg_type;
endpackage
`default_nettype wire

//--- dss_cmd_decode.sv
// three-wire / two-wire terminal decoding with run latch
// assumes terminal inputs are synchronous to clk and debounced outside
`default_nettype none
module dss_cmd_decode #(
    parameter int unsigned RUN_HOLD_CYC = dss_pkg::RUN_HOLD_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [4:0] input_function_is_dir,
    input wire logic [4:0] terminals,
    input wire logic [15:0] init_code_select,
    output logic run_cmd,
    output logic reverse_cmd,
    output logic three_wire
);
    logic [22:0] hold_cnt_r, hold_cnt_nxt;
    logic latch_r, latch_nxt;
    logic dir_level;
    logic init3;
    logic run_in, stop_in;

    assign init3 = init_code_select == dss_pkg::INIT_THREE_WIRE;
    assign three_wire = |input_function_is_dir || init3; // R1
    // fifth terminal (terminals[4]) is direction under the init code
    assign dir_level = init3 ? terminals[4] : // R2
        |(input_function_is_dir & terminals);
    assign run_in = terminals[0];
    assign stop_in = terminals[2];

    always_comb begin
        hold_cnt_nxt = hold_cnt_r;
        latch_nxt = latch_r;
        if (!three_wire || !stop_in) begin
            latch_nxt = 1'b0; // R18
            hold_cnt_nxt = '0;
        end else if (run_in) begin
            if (hold_cnt_r < 23'(RUN_HOLD_CYC - 1))
                hold_cnt_nxt = hold_cnt_r + 23'h1;
            else
                latch_nxt = 1'b1; // R3
        end else begin
            hold_cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_cnt_r <= '0;
            latch_r <= 1'b0;
        end else if (clk_en) begin
            hold_cnt_r <= hold_cnt_nxt;
            latch_r <= latch_nxt;
        end
    end

    // two-wire: forward while first input, reverse while second
    assign run_cmd = three_wire ? latch_r :
        (terminals[0] ^ terminals[1]); // R17
    assign reverse_cmd = three_wire ? dir_level : terminals[1]; // R18

    AST_LATCH_NEEDS_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(latch_r) |-> $past(run_in) && $past(stop_in) &&
        $past(three_wire)) // R3
        else $error("run latched without held run input");
    AST_STOP_CLEARS: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && three_wire && !stop_in |=> !latch_r) // R18
        else $error("stop did not clear run latch");
endmodule // dss_cmd_decode
`default_nettype wire

//--- dss_sequencer.sv
// stop/start sequencer: ramps, dc injection, output cut and run inhibit
// assumes config words are in range and steady; times in 10 ms ticks
`default_nettype none
module dss_sequencer #(
    parameter int unsigned TICK_CYC = dss_pkg::TICK_CYC,
    parameter int unsigned RUN_HOLD_CYC = dss_pkg::RUN_HOLD_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [4:0] input_function_is_dir,
    input wire logic [4:0] terminals,
    input wire logic [15:0] init_code_select,
    input wire dss_pkg::dss_cfg_type cfg,
    input wire logic [15:0] target_frequency,
    output logic [15:0] output_frequency,
    output logic output_enable,
    output logic dc_inject,
    output logic [6:0] dc_current_percent,
    output logic reverse,
    output logic running,
    output logic run_inhibited,
    output logic [1:0] active_stop_method
);
    dss_pkg::dss_state_type st_r, st_nxt;
    logic [15:0] freq_r, freq_nxt, timer_r, timer_nxt;
    logic [15:0] brake_len_r, brake_len_nxt;
    logic [31:0] dec_sum, dec_step;
    logic run_r, run_nxt, inh_r, inh_nxt;
    logic [1:0] method_r, method_nxt;
    logic [6:0] cur_r, cur_nxt;
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic [31:0] step_acc_r, step_acc_nxt;
    logic rev_r, rev_nxt, oe_r, oe_nxt, dc_r, dc_nxt;
    logic run_cmd, rev_cmd, tick;
    logic [15:0] zero_lvl;

    // time scaled by frequency ratio, used for brake length and inhibit
    function automatic logic [15:0] scale_time(input logic [15:0] t,
        input logic [15:0] f, input logic [15:0] fmax);
        logic [31:0] p;
        p = 32'(t) * 32'(f);
        if (fmax == 16'h0)
            return t;
        return 16'(p / 32'(fmax));
    endfunction

    dss_cmd_decode #(.RUN_HOLD_CYC(RUN_HOLD_CYC)) u_cmd (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .input_function_is_dir(input_function_is_dir),
        .terminals(terminals),
        .init_code_select(init_code_select),
        .run_cmd(run_cmd),
        .reverse_cmd(rev_cmd),
        .three_wire()
    );

    assign tick = tick_cnt_r == 32'(TICK_CYC - 1);
    // never start braking below the minimum output frequency
    assign zero_lvl = (cfg.brake_start_frequency < cfg.min_output_frequency) ?
        cfg.min_output_frequency : cfg.brake_start_frequency; // R7

    always_comb begin
        st_nxt = st_r;
        freq_nxt = freq_r;
        timer_nxt = timer_r;
        brake_len_nxt = brake_len_r;
        method_nxt = method_r;
        cur_nxt = cur_r;
        rev_nxt = rev_r;
        oe_nxt = oe_r;
        dc_nxt = dc_r;
        step_acc_nxt = step_acc_r;
        dec_sum = step_acc_r + 32'(cfg.max_output_frequency);
        dec_step = (cfg.first_decel_time == 16'h0) ? 32'(freq_r) :
            dec_sum / 32'(cfg.first_decel_time);
        tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
        if (timer_r != 16'h0 && tick)
            timer_nxt = timer_r - 16'h1;
        // clamp keeps an oversized setting at full rating
        cur_nxt = (cfg.brake_current_percent > dss_pkg::BRAKE_PCT_MAX) ?
            dss_pkg::BRAKE_PCT_MAX : cfg.brake_current_percent; // R8
        case (st_r)
            dss_pkg::ST_IDLE: begin
                oe_nxt = 1'b0;
                dc_nxt = 1'b0;
                freq_nxt = 16'h0;
                method_nxt = cfg.stop_method_select; // R4
                if (run_cmd) begin
                    rev_nxt = rev_cmd;
                    timer_nxt = cfg.start_brake_time;
                    st_nxt = (cfg.start_brake_time != 16'h0) ?
                        dss_pkg::ST_START_BRAKE : dss_pkg::ST_RUN; // R15
                    dc_nxt = cfg.start_brake_time != 16'h0; // R15
                    oe_nxt = cfg.start_brake_time == 16'h0;
                end
            end
            dss_pkg::ST_START_BRAKE: begin
                if (timer_r == 16'h0) begin
                    dc_nxt = 1'b0;
                    oe_nxt = 1'b1;
                    st_nxt = dss_pkg::ST_RUN;
                end
            end
            dss_pkg::ST_RUN: begin
                freq_nxt = target_frequency;
                rev_nxt = rev_cmd;
                if (!run_cmd) begin
                    case (method_r)
                        dss_pkg::STOP_DECEL: begin
                            st_nxt = dss_pkg::ST_DECEL; // R5
                            step_acc_nxt = 32'h0;
                        end
                        dss_pkg::STOP_COAST: begin
                            oe_nxt = 1'b0; // R10
                            freq_nxt = 16'h0;
                            timer_nxt = cfg.min_output_off_time;
                            brake_len_nxt = 16'h0;
                            st_nxt = dss_pkg::ST_INHIBIT; // R11
                        end
                        dss_pkg::STOP_DCBRAKE: begin
                            oe_nxt = 1'b0;
                            freq_nxt = 16'h0;
                            timer_nxt = cfg.min_output_off_time; // R12
                            brake_len_nxt = scale_time(cfg.stop_brake_time,
                                freq_r, cfg.max_output_frequency); // R13
                            st_nxt = dss_pkg::ST_OFF_WAIT;
                        end
                        default: begin
                            oe_nxt = 1'b0;
                            freq_nxt = 16'h0;
                            timer_nxt = scale_time(cfg.first_decel_time,
                                freq_r, cfg.max_output_frequency); // R14
                            st_nxt = dss_pkg::ST_INHIBIT;
                        end
                    endcase
                end
            end
            dss_pkg::ST_DECEL: begin
                // decel time covers max frequency to zero; remainder carried
                if (tick) begin
                    step_acc_nxt = (cfg.first_decel_time == 16'h0) ? 32'h0 :
                        dec_sum % 32'(cfg.first_decel_time);
                    freq_nxt = (32'(freq_r) > dec_step) ?
                        16'(32'(freq_r) - dec_step) : 16'h0; // R5
                end
                if (freq_r < zero_lvl) begin
                    oe_nxt = 1'b0;
                    freq_nxt = 16'h0;
                    timer_nxt = cfg.stop_brake_time;
                    dc_nxt = cfg.stop_brake_time != 16'h0; // R9
                    st_nxt = (cfg.stop_brake_time != 16'h0) ?
                        dss_pkg::ST_STOP_BRAKE : dss_pkg::ST_IDLE; // R6
                end
            end
            dss_pkg::ST_OFF_WAIT: begin
                // longer off time lets flux decay, avoiding overcurrent
                if (timer_r == 16'h0) begin
                    timer_nxt = brake_len_r;
                    dc_nxt = brake_len_r != 16'h0; // R12
                    st_nxt = (brake_len_r != 16'h0) ?
                        dss_pkg::ST_STOP_BRAKE : dss_pkg::ST_IDLE;
                end
            end
            dss_pkg::ST_STOP_BRAKE: begin
                if (timer_r == 16'h0) begin
                    dc_nxt = 1'b0; // R6
                    st_nxt = dss_pkg::ST_IDLE;
                end
            end
            dss_pkg::ST_INHIBIT: begin
                if (timer_r == 16'h0)
                    st_nxt = dss_pkg::ST_IDLE; // R11
            end
            default: begin
                st_nxt = dss_pkg::ST_IDLE;
                oe_nxt = 1'b0;
                dc_nxt = 1'b0;
            end
        endcase
        // restart the tick on a state change so timed states are not short
        if (st_nxt != st_r)
            tick_cnt_nxt = 32'h0;
        run_nxt = st_nxt == dss_pkg::ST_RUN;
        inh_nxt = st_nxt == dss_pkg::ST_INHIBIT ||
            st_nxt == dss_pkg::ST_OFF_WAIT;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= dss_pkg::ST_IDLE;
            freq_r <= 16'h0;
            timer_r <= 16'h0;
            brake_len_r <= 16'h0;
            method_r <= dss_pkg::STOP_DECEL;
            cur_r <= dss_pkg::BRAKE_PCT_DEF;
            tick_cnt_r <= 32'h0;
            step_acc_r <= 32'h0;
            rev_r <= 1'b0;
            oe_r <= 1'b0;
            dc_r <= 1'b0;
            run_r <= 1'b0;
            inh_r <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            freq_r <= freq_nxt;
            timer_r <= timer_nxt;
            brake_len_r <= brake_len_nxt;
            method_r <= method_nxt;
            cur_r <= cur_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            step_acc_r <= step_acc_nxt;
            rev_r <= rev_nxt;
            oe_r <= oe_nxt;
            dc_r <= dc_nxt;
            run_r <= run_nxt;
            inh_r <= inh_nxt;
        end
    end

    assign output_frequency = freq_r;
    assign output_enable = oe_r;
    assign dc_inject = dc_r;
    assign dc_current_percent = cur_r;
    assign reverse = rev_r;
    assign running = run_r;
    assign run_inhibited = inh_r;
    assign active_stop_method = method_r;

    AST_METHOD_FROZEN: assert property (@(posedge clk) disable iff (!reset_n)
        st_r != dss_pkg::ST_IDLE |=> $stable(method_r)) // R4
        else $error("stop method changed while active");
    AST_COAST_CUTS: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && st_r == dss_pkg::ST_RUN && !run_cmd &&
        method_r == dss_pkg::STOP_COAST |=> !oe_r && !dc_r) // R10
        else $error("coast stop did not cut output");
    AST_INHIBIT_NO_RUN: assert property (@(posedge clk) disable iff (!reset_n)
        st_r == dss_pkg::ST_INHIBIT |=> st_r != dss_pkg::ST_RUN) // R11
        else $error("run accepted during inhibit");
    AST_OFF_BEFORE_DC: assert property (@(posedge clk) disable iff (!reset_n)
        st_r == dss_pkg::ST_OFF_WAIT && timer_r != 16'h0 |-> !dc_r) // R12
        else $error("dc injected during off wait");
    AST_ZERO_STOP_TIME: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && st_r == dss_pkg::ST_DECEL && freq_r < zero_lvl &&
        cfg.stop_brake_time == 16'h0 |=> !dc_r && st_r == dss_pkg::ST_IDLE) // R9
        else $error("dc injected with zero stop time");
    AST_START_SKIP: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && st_r == dss_pkg::ST_IDLE && run_cmd &&
        cfg.start_brake_time == 16'h0 |=> st_r == dss_pkg::ST_RUN && oe_r) // R15
        else $error("start brake not skipped");
    AST_DC_EXCLUSIVE: assert property (@(posedge clk) disable iff (!reset_n)
        !(dc_r && oe_r)) // R6
        else $error("dc injection overlaps output");
    AST_DECEL_DOWN: assert property (@(posedge clk) disable iff (!reset_n)
        st_r == dss_pkg::ST_DECEL && $past(st_r) == dss_pkg::ST_DECEL
        |-> freq_r <= $past(freq_r)) // R5
        else $error("frequency rose while decelerating");
endmodule // dss_sequencer
`default_nettype wire

//--- dss_term_model.sv
// terminal driver model: switches or a controller on the control terminals
// assumes clk is the design clock; levels change 1 ns after a rising edge
`default_nettype none
module dss_term_model (
    input wire logic clk,
    output logic [4:0] terminals
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        terminals = 5'h00;
    end

    // levels only; a real switch never glitches inside a cycle here
    task automatic set_level(input logic [4:0] v);
        @(posedge clk);
        #1;
        terminals = v;
    endtask

    // three-wire run press with stop held; hold is the caller's choice
    task automatic press_run(input logic [4:0] base, input int hold);
        set_level(base | 5'h01);
        repeat (hold) @(posedge clk);
        #1;
        terminals = base;
    endtask
endmodule // dss_term_model
`default_nettype wire

//--- tb_drive_stop_sequencer.sv
// self-checking bench for the stop sequencer, two-wire traffic mostly
// assumes dss_pkg and dss_sequencer; tick shortened to 10 cycles
`default_nettype none
module tb_drive_stop_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TK = 10;
    localparam int LIMIT = 20000;
    logic clk, reset_n, clk_en;
    logic [4:0] input_function_is_dir;
    logic [4:0] terminals;
    logic [15:0] init_code_select, target_frequency, output_frequency;
    dss_pkg::dss_cfg_type cfg;
    logic output_enable, dc_inject, reverse, running, run_inhibited;
    logic [6:0] dc_current_percent;
    logic [1:0] active_stop_method;
    int err_total, cmp_count, cycles, n;

    dss_term_model partner (.clk(clk), .terminals(terminals));

    dss_sequencer #(.TICK_CYC(TK), .RUN_HOLD_CYC(5 * TK)) uut (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .input_function_is_dir(input_function_is_dir),
        .terminals(terminals), .init_code_select(init_code_select),
        .cfg(cfg), .target_frequency(target_frequency),
        .output_frequency(output_frequency), .output_enable(output_enable),
        .dc_inject(dc_inject), .dc_current_percent(dc_current_percent),
        .reverse(reverse), .running(running), .run_inhibited(run_inhibited),
        .active_stop_method(active_stop_method)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard, well above the roughly 1600 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            $display("BAD timeout expected %0d seen %0d", LIMIT - 1, cycles);
            stop_test();
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return dc_inject;
            1: return output_enable;
            2: return run_inhibited;
            default: return running;
        endcase
    endfunction

    // counts cycles while a watched output holds a level, bounded
    task automatic dur(input int w, input logic lv, output int k);
        k = 0;
        while (sig(w) === lv && k < 400) begin
            cyc(1);
            k++;
        end
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // timing checks allow a few cycles of pipeline slack; the zero-speed and min-frequency waits allow ticks
    task automatic rng(input string nm, input int lo, input int hi,
                       input int g);
        cmp_count++;
        if (g < lo || g > hi) begin
            err_total++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic run_on(input logic [4:0] t);
        partner.set_level(t);
        dur(3, 1'b0, n);
        chk("running", 16'h0001, {15'h0000, running});
    endtask

    task automatic settle();
        partner.set_level(5'h00);
        dur(1, 1'b1, n);
        dur(0, 1'b1, n);
        dur(2, 1'b1, n);
        cyc(2);
    endtask

    task automatic decel_stop(output int k);
        run_on(5'h01);
        partner.set_level(5'h00);
        dur(0, 1'b0, k);
    endtask

    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        input_function_is_dir = 5'h00;
        init_code_select = 16'h0000;
        target_frequency = 16'h0064;
        cfg = '{2'h1, 16'h0005, 7'h50, 16'h0000, 16'h0003, 16'h0005,
                16'h0000, 16'h000a, 16'h0064};
        cyc(1);
        chk("reset current", 16'h0032, {9'h000, dc_current_percent});
        chk("reset enable", 16'h0000, {15'h0000, output_enable});
        cyc(1);
        reset_n = 1'b1;
        cyc(2);
        $display("test reset done");

        run_on(5'h01);
        chk("forward", 16'h0000, {15'h0000, reverse});
        clk_en = 1'b0;
        partner.set_level(5'h00);
        cyc(3);
        chk("frozen", 16'h0001, {15'h0000, running});
        clk_en = 1'b1;
        cyc(3);
        chk("coast cut", 16'h0000, {15'h0000, output_enable});
        partner.set_level(5'h01);
        cyc(1);
        chk("run ignored", 16'h0000, {15'h0000, running});
        dur(2, 1'b1, n);
        rng("off time", 5 * TK - 8, 5 * TK + 3, n);
        dur(3, 1'b0, n);
        chk("rerun", 16'h0001, {15'h0000, running});
        settle();
        run_on(5'h02);
        chk("reverse", 16'h0001, {15'h0000, reverse});
        settle();
        $display("test coast done");

        cfg.stop_method_select = 2'h0;
        cyc(2);
        decel_stop(n);
        rng("zero speed wait", 9 * TK, 11 * TK + 5, n);
        chk("ramp mode", 16'h0000, {14'h0000, active_stop_method});
        rng("zero speed freq", 0, 4, int'(output_frequency));
        chk("brake current", 16'h0050, {9'h000, dc_current_percent});
        dur(0, 1'b1, n);
        rng("stop brake", 3 * TK - 3, 3 * TK + 3, n);
        settle();
        cfg.min_output_frequency = 16'h003c;
        cfg.brake_start_frequency = 16'h0002;
        cyc(2);
        decel_stop(n);
        rng("min freq start", 4 * TK, 7 * TK, n);
        settle();
        cfg.stop_brake_time = 16'h0000;
        cyc(2);
        decel_stop(n);
        chk("no stop brake", 16'h0000, {15'h0000, dc_inject});
        settle();
        $display("test decel done");

        cfg.stop_method_select = 2'h2;
        cfg.stop_brake_time = 16'h000a;
        target_frequency = 16'h0032;
        cfg.min_output_off_time = 16'h0006;
        cyc(2);
        run_on(5'h01);
        partner.set_level(5'h00);
        cyc(3);
        chk("dc wait cut", 16'h0000, {15'h0000, output_enable});
        dur(0, 1'b0, n);
        rng("dc wait", 6 * TK - 8, 6 * TK + 3, n);
        dur(0, 1'b1, n);
        rng("dc length", 5 * TK - 3, 5 * TK + 3, n);
        settle();
        $display("test dc stop done");

        cfg.stop_method_select = 2'h3;
        target_frequency = 16'h0064;
        cyc(2);
        run_on(5'h01);
        partner.set_level(5'h00);
        cyc(3);
        chk("timed cut", 16'h0000, {15'h0000, output_enable});
        dur(2, 1'b1, n);
        rng("timed inhibit", 10 * TK - 8, 10 * TK + 3, n);
        settle();
        $display("test timed coast done");

        cfg.stop_method_select = 2'h1;
        cfg.start_brake_time = 16'h0004;
        cyc(2);
        partner.set_level(5'h01);
        dur(0, 1'b0, n);
        rng("start brake wait", 0, 5, n);
        dur(0, 1'b1, n);
        rng("start brake", 4 * TK - 3, 4 * TK + 3, n);
        cyc(2);
        chk("start output", 16'h0001, {15'h0000, output_enable});
        cfg.stop_method_select = 2'h0;
        partner.set_level(5'h00);
        cyc(3);
        chk("method frozen", 16'h0001, {14'h0000, active_stop_method});
        chk("still coast", 16'h0000, {15'h0000, output_enable});
        settle();
        $display("test start brake done");

        input_function_is_dir = 5'h08;
        partner.set_level(5'h04);
        partner.press_run(5'h04, 20);
        cyc(5);
        chk("short press", 16'h0000, {15'h0000, running});
        partner.press_run(5'h0c, 60);
        dur(3, 1'b0, n);
        chk("latched run", 16'h0001, {15'h0000, running});
        chk("dir input", 16'h0001, {15'h0000, reverse});
        partner.set_level(5'h08);
        cyc(3);
        chk("stop clears", 16'h0000, {15'h0000, running});
        settle();
        input_function_is_dir = 5'h00;
        init_code_select = 16'h0d02;
        partner.press_run(5'h14, 60);
        dur(3, 1'b0, n);
        chk("init run", 16'h0001, {15'h0000, running});
        chk("init dir", 16'h0001, {15'h0000, reverse});
        settle();
        $display("test three wire done");
        stop_test();
    end
endmodule // tb_drive_stop_sequencer
`default_nettype wire
